/* File: logic/codec_ctrl_defs.svh */
// Offsets, field positions, reset values and strap defaults of the codec control bank
`ifndef CODEC_CTRL_DEFS_SVH
`define CODEC_CTRL_DEFS_SVH

`define REG_COUNT        36
`define REG_LAST         6'h23
`define OFF_PLL_A_INT    6'h02
`define OFF_PRI_TX_CLK   6'h0A
`define OFF_ZERO_FLAG    6'h10
`define OFF_MUTE_CTRL    6'h13
`define OFF_ADC_CTRL     6'h1D
`define OFF_PWR_MAIN     6'h32
`define OFF_PWR_AUX      6'h33
`define OFF_READBACK     6'h34

`define OFF_PLL_A_FRAC_LOW 6'h00
`define OFF_PLL_A_FRAC_MID 6'h01
`define OFF_PLL_A_SCALE    6'h03
`define OFF_PLL_B_FRAC_LOW 6'h04
`define OFF_PLL_B_FRAC_MID 6'h05
`define OFF_PLL_B_INT      6'h06
`define OFF_PLL_B_SCALE    6'h07
`define OFF_CLK_SEL        6'h08
`define OFF_PRI_RX_CLK     6'h09
`define OFF_SEC_CLK        6'h0B
`define OFF_PRI_RX_FMT     6'h0C
`define OFF_PRI_TX_FMT     6'h0D
`define OFF_SEC_FMT        6'h0E
`define OFF_DAC_SEL        6'h0F
`define OFF_DEEMPH         6'h11
`define OFF_OUT_PHASE      6'h12
`define OFF_ATTEN_D1L      6'h14
`define OFF_ATTEN_D1R      6'h15
`define OFF_ATTEN_D2L      6'h16
`define OFF_ATTEN_D2R      6'h17
`define OFF_ATTEN_D3L      6'h18
`define OFF_ATTEN_D3R      6'h19
`define OFF_ATTEN_D4L      6'h1A
`define OFF_ATTEN_D4R      6'h1B
`define OFF_ATTEN_MASTER   6'h1C
`define OFF_SPDIF_SRC      6'h1E
`define OFF_SPDIF_STAT0    6'h1F
`define OFF_SPDIF_CAT      6'h20
`define OFF_SPDIF_CHAN     6'h21
`define OFF_SPDIF_FREQ     6'h22
`define OFF_SPDIF_WLEN     6'h23

`define RST_PLL_A_FRAC_LOW 9'h121
`define RST_PLL_A_FRAC_MID 9'h17E
`define RST_PLL_A_INT      9'h07D
`define RST_PLL_A_SCALE    9'h014
`define RST_PLL_B_FRAC_LOW 9'h121
`define RST_PLL_B_FRAC_MID 9'h17E
`define RST_PLL_B_INT      9'h07D
`define RST_PLL_B_SCALE    9'h194
`define RST_CLK_SEL        9'h010
`define RST_PRI_RX_CLK     9'h002
`define RST_PRI_TX_CLK     9'h002
`define RST_SEC_CLK        9'h0C2
`define RST_PRI_RX_FMT     9'h18A
`define RST_PRI_TX_FMT     9'h08A
`define RST_SEC_FMT        9'h00A
`define RST_DAC_SEL        9'h0E4
`define RST_ZERO_FLAG      9'h009
`define RST_DEEMPH         9'h000
`define RST_OUT_PHASE      9'h0FF
`define RST_MUTE_CTRL      9'h000
`define RST_ATTEN          9'h0FF
`define RST_ADC_CTRL       9'h040
`define RST_SPDIF_SRC      9'h000
`define RST_SPDIF_STAT0    9'h000
`define RST_SPDIF_CAT      9'h000
`define RST_SPDIF_CHAN     9'h000
`define RST_SPDIF_FREQ     9'h031
`define RST_SPDIF_WLEN     9'h00B

`define FLD_RATE_LSB     0
`define FLD_BCLK_LSB     3
`define FLD_PWR_GLOBAL   0
`define FLD_PWR_ADC      1
`define FLD_PWR_DAC_LSB  2
`define FLD_PWR_ALL_DAC  6

`define RST_PWR_MAIN     9'h07E
`define RST_PWR_AUX      9'h03E
`define RST_READBACK     9'h000

`define FLD_PER_DAC_MUTE_PIN_DISABLE       7
`define FLD_ZERO_FLAG_DAC_SELECT_LSB     4
`define FLD_TXMS         5
`define FLD_CONTINUOUS_READBACK_ENABLE     3
`define FLD_RATE_256     3'h2
`define FLD_BCLK_64      2'h0

`endif

/* File: logic/codec_ctrl_pkg.sv */
// Types shared by the codec control bank
package codec_ctrl_pkg;
  typedef logic [8:0] reg_word_t;

  typedef struct packed {
    logic       master;
    logic [2:0] clock_ratio;
    logic [1:0] bclk_select;
  } tx_clocking_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [5:0] addr;
    logic [8:0] wdata;
  } reg_access_t;

  typedef enum logic [0:0] {
    CTRL_SOFTWARE = 1'b0,
    CTRL_HARDWARE = 1'b1
  } ctrl_mode_t;
endpackage

/* File: logic/codec_control_regs_hw_mode.sv */
// Control register bank and hardware control mode pin logic
`timescale 1ns/10ps
`include "codec_ctrl_defs.svh"

module codec_control_regs_hw_mode
  import codec_ctrl_pkg::*;
#(
  parameter logic [8:0] ID_CODE_0   = 9'h0A5,
  parameter logic [8:0] ID_CODE_1   = 9'h05A,
  parameter logic [8:0] REVISION    = 9'h001,
  parameter int         DAC_COUNT   = 4
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 hardware_mode_strap_i,
  input  wire reg_access_t          access_i,
  output      reg_word_t            rdata_o,
  output      logic                 rvalid_o,
  input  wire logic                 mute_pin_i,
  input  wire logic                 mute_pin_floating_i,
  output      logic                 mute_pin_o,
  output      logic                 mute_pin_oe_o,
  input  wire logic [DAC_COUNT-1:0] dac_zero_i,
  output      logic [DAC_COUNT-1:0] dac_soft_mute_o,
  input  wire logic                 serial_data_in_strap_i,
  output      tx_clocking_t         primary_tx_o,
  input  wire logic                 global_powerdown_pin_i,
  input  wire logic                 secondary_if_lr_clock_i,
  output      logic                 secondary_if_lr_clock_sel_o,
  output      logic                 general_output_seven_o,
  output      logic                 powerdown_all_o,
  output      logic [DAC_COUNT-1:0] dac_powerdown_o,
  output      reg_word_t            pwr_main_o,
  output      reg_word_t            pwr_aux_o,
  output      ctrl_mode_t           mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  reg_word_t            bank [`REG_COUNT];
  reg_word_t            pwr_main;
  reg_word_t            pwr_aux;
  reg_word_t            readback;
  ctrl_mode_t           mode;
  reg_word_t            next_rdata;
  logic                 sw_mode;
  logic                 mute_req;
  logic [2:0]           zf_sel;
  logic                 mute_pin_disable;
  logic                 tx_master_bit;
  logic [2:0]           tx_ratio_bits;
  logic [1:0]           tx_bclk_bits;
  logic                 continuous_readback_enable;
  logic                 pwr_global;
  logic [DAC_COUNT-1:0] pwr_dac;
  logic                 pwr_all_dac;
  logic                 pwr_fully_down;
  logic                 id_window;

  function automatic logic in_bank(input logic [5:0] a);
    return a <= `REG_LAST;
  endfunction

  // Addresses past the bank have no default and never reach this
  function automatic reg_word_t reg_default(input logic [5:0] a);
    reg_word_t v;
    v = 9'h000;
    unique case (a)
      `OFF_PLL_A_FRAC_LOW: begin
        v = `RST_PLL_A_FRAC_LOW;
      end
      `OFF_PLL_A_FRAC_MID: begin
        v = `RST_PLL_A_FRAC_MID;
      end
      `OFF_PLL_A_INT: begin
        v = `RST_PLL_A_INT;
      end
      `OFF_PLL_A_SCALE: begin
        v = `RST_PLL_A_SCALE;
      end
      `OFF_PLL_B_FRAC_LOW: begin
        v = `RST_PLL_B_FRAC_LOW;
      end
      `OFF_PLL_B_FRAC_MID: begin
        v = `RST_PLL_B_FRAC_MID;
      end
      `OFF_PLL_B_INT: begin
        v = `RST_PLL_B_INT;
      end
      `OFF_PLL_B_SCALE: begin
        v = `RST_PLL_B_SCALE;
      end
      `OFF_CLK_SEL: begin
        v = `RST_CLK_SEL;
      end
      `OFF_PRI_RX_CLK: begin
        v = `RST_PRI_RX_CLK;
      end
      `OFF_PRI_TX_CLK: begin
        v = `RST_PRI_TX_CLK;
      end
      `OFF_SEC_CLK: begin
        v = `RST_SEC_CLK;
      end
      `OFF_PRI_RX_FMT: begin
        v = `RST_PRI_RX_FMT;
      end
      `OFF_PRI_TX_FMT: begin
        v = `RST_PRI_TX_FMT;
      end
      `OFF_SEC_FMT: begin
        v = `RST_SEC_FMT;
      end
      `OFF_DAC_SEL: begin
        v = `RST_DAC_SEL;
      end
      `OFF_ZERO_FLAG: begin
        v = `RST_ZERO_FLAG;
      end
      `OFF_DEEMPH: begin
        v = `RST_DEEMPH;
      end
      `OFF_OUT_PHASE: begin
        v = `RST_OUT_PHASE;
      end
      `OFF_MUTE_CTRL: begin
        v = `RST_MUTE_CTRL;
      end
      `OFF_ATTEN_D1L: begin
        v = `RST_ATTEN;
      end
      `OFF_ATTEN_D1R: begin
        v = `RST_ATTEN;
      end
      `OFF_ATTEN_D2L: begin
        v = `RST_ATTEN;
      end
      `OFF_ATTEN_D2R: begin
        v = `RST_ATTEN;
      end
      `OFF_ATTEN_D3L: begin
        v = `RST_ATTEN;
      end
      `OFF_ATTEN_D3R: begin
        v = `RST_ATTEN;
      end
      `OFF_ATTEN_D4L: begin
        v = `RST_ATTEN;
      end
      `OFF_ATTEN_D4R: begin
        v = `RST_ATTEN;
      end
      `OFF_ATTEN_MASTER: begin
        v = `RST_ATTEN;
      end
      `OFF_ADC_CTRL: begin
        v = `RST_ADC_CTRL;
      end
      `OFF_SPDIF_SRC: begin
        v = `RST_SPDIF_SRC;
      end
      `OFF_SPDIF_STAT0: begin
        v = `RST_SPDIF_STAT0;
      end
      `OFF_SPDIF_CAT: begin
        v = `RST_SPDIF_CAT;
      end
      `OFF_SPDIF_CHAN: begin
        v = `RST_SPDIF_CHAN;
      end
      `OFF_SPDIF_FREQ: begin
        v = `RST_SPDIF_FREQ;
      end
      `OFF_SPDIF_WLEN: begin
        v = `RST_SPDIF_WLEN;
      end
      default: begin
        v = 9'h000;
      end
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Named fields of the control words
  assign zf_sel           = bank[`OFF_ZERO_FLAG][`FLD_ZERO_FLAG_DAC_SELECT_LSB +: 3];
  assign mute_pin_disable = bank[`OFF_MUTE_CTRL][`FLD_PER_DAC_MUTE_PIN_DISABLE];
  assign tx_master_bit    = bank[`OFF_PRI_TX_CLK][`FLD_TXMS];
  assign tx_ratio_bits    = bank[`OFF_PRI_TX_CLK][`FLD_RATE_LSB +: 3];
  assign tx_bclk_bits     = bank[`OFF_PRI_TX_CLK][`FLD_BCLK_LSB +: 2];
  assign continuous_readback_enable         = readback[`FLD_CONTINUOUS_READBACK_ENABLE];
  assign pwr_global       = pwr_main[`FLD_PWR_GLOBAL];
  assign pwr_dac          = pwr_main[`FLD_PWR_DAC_LSB +: DAC_COUNT];
  assign pwr_all_dac      = pwr_main[`FLD_PWR_ALL_DAC];
  // Fully down while the global bit is set or every block bit is set
  assign pwr_fully_down   = pwr_global | (&pwr_main[`FLD_PWR_ALL_DAC:`FLD_PWR_ADC]);
  assign id_window        = (access_i.addr <= `OFF_PLL_A_INT) && !continuous_readback_enable;

  // Mode is caught by a clocked process, so the strap can settle after reset
  // mode strap select
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mode <= CTRL_SOFTWARE;
    end else begin
      mode <= hardware_mode_strap_i ? CTRL_HARDWARE : CTRL_SOFTWARE;
    end
  end
  assign sw_mode = (mode == CTRL_SOFTWARE);
  assign mode_o  = mode;

  genvar gi;
  generate
    for (gi = 0; gi < `REG_COUNT; gi++) begin : g_bank
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          bank[gi] <= reg_default(6'(gi));
        end else if (access_i.write && access_i.addr == 6'(gi)) begin
          bank[gi] <= access_i.wdata;
        end
      end
    end
  endgenerate

  // Powerdown and readback controls sit above the window of this bank
  // powered down at reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pwr_main <= `RST_PWR_MAIN;
    end else if (access_i.write && access_i.addr == `OFF_PWR_MAIN) begin
      pwr_main <= access_i.wdata;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pwr_aux <= `RST_PWR_AUX;
    end else if (access_i.write && access_i.addr == `OFF_PWR_AUX) begin
      pwr_aux <= access_i.wdata;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      readback <= `RST_READBACK;
    end else if (access_i.write && access_i.addr == `OFF_READBACK) begin
      readback <= access_i.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback
  // identity readback
  always_comb begin
    next_rdata = 9'h000;
    if (id_window) begin
      unique case (access_i.addr[1:0])
        2'h0:    next_rdata = ID_CODE_0;
        2'h1:    next_rdata = ID_CODE_1;
        default: next_rdata = REVISION;
      endcase
    end else if (in_bank(access_i.addr)) begin
      next_rdata = bank[access_i.addr];
    end else begin
      unique case (access_i.addr)
        `OFF_PWR_MAIN: next_rdata = pwr_main;
        `OFF_PWR_AUX:  next_rdata = pwr_aux;
        `OFF_READBACK: next_rdata = readback;
        default:       next_rdata = 9'h000;
      endcase
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_o <= 9'h000;
    end else if (access_i.read) begin
      rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= access_i.read;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mute pin and zero flag
  // A floating pin is an output, so its own level never mutes
  assign mute_req = mute_pin_i && !mute_pin_floating_i;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dac_soft_mute_o <= '0;
    end else begin
      for (int i = 0; i < DAC_COUNT; i++) begin
        if (!sw_mode) begin
          dac_soft_mute_o[i] <= mute_req;
        end else begin
          dac_soft_mute_o[i] <= mute_req && !mute_pin_disable && zf_sel == 3'(i);
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mute_pin_oe_o <= 1'b0;
    end else begin
      mute_pin_oe_o <= mute_pin_floating_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mute_pin_o <= 1'b0;
    end else begin
      mute_pin_o <= &dac_zero_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Primary transmitter clocking
  // strap sets master
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      primary_tx_o <= '{master: 1'b0, clock_ratio: `FLD_RATE_256, bclk_select: `FLD_BCLK_64};
    end else if (!sw_mode) begin
      primary_tx_o <= '{master: serial_data_in_strap_i, clock_ratio: `FLD_RATE_256, bclk_select: `FLD_BCLK_64};
    end else begin
      primary_tx_o.master      <= tx_master_bit;
      primary_tx_o.clock_ratio <= tx_ratio_bits;
      primary_tx_o.bclk_select <= tx_bclk_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power control and multifunction pin seven
  // pin controls power
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      powerdown_all_o <= 1'b1;
    end else if (!sw_mode) begin
      powerdown_all_o <= global_powerdown_pin_i;
    end else begin
      powerdown_all_o <= pwr_fully_down;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dac_powerdown_o <= '1;
    end else if (!sw_mode) begin
      dac_powerdown_o <= {DAC_COUNT{global_powerdown_pin_i}};
    end else begin
      dac_powerdown_o <= pwr_dac | {DAC_COUNT{pwr_all_dac}};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      secondary_if_lr_clock_sel_o <= 1'b0;
      general_output_seven_o      <= 1'b0;
    end else begin
      secondary_if_lr_clock_sel_o <= sw_mode;
      general_output_seven_o      <= sw_mode && secondary_if_lr_clock_i;
    end
  end

  assign pwr_main_o = pwr_main;
  assign pwr_aux_o  = pwr_aux;

endmodule

/* File: verification/codec_ctrl_asserts.sv */
// Port checks for the codec control bank
`timescale 1ns/10ps
module codec_ctrl_asserts import codec_ctrl_pkg::*; #(parameter int DAC_COUNT = 4) (
  input wire logic                 clk_sys_i, rst_n_i, hardware_mode_strap_i, rvalid_o,
  input wire reg_access_t          access_i,
  input wire logic                 mute_pin_i, mute_pin_floating_i, mute_pin_o, mute_pin_oe_o,
  input wire logic [DAC_COUNT-1:0] dac_zero_i, dac_soft_mute_o, dac_powerdown_o,
  input wire logic                 serial_data_in_strap_i, global_powerdown_pin_i, powerdown_all_o,
  input wire logic                 secondary_if_lr_clock_sel_o,
  input wire tx_clocking_t         primary_tx_o,
  input wire ctrl_mode_t           mode_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_hw; mode_o == CTRL_HARDWARE; endsequence
  // Two cycles because the select is registered one cycle after the mode
  sequence s_sw_held; mode_o == CTRL_SOFTWARE [*2]; endsequence
  property p_read; access_i.read |=> rvalid_o; endproperty
  a_read: assert property (p_read) else $error("read unanswered");
  property p_hw_mute;
    s_hw |=> dac_soft_mute_o == {DAC_COUNT{$past(mute_pin_i) & !$past(mute_pin_floating_i)}};
  endproperty
  a_hw_mute: assert property (p_hw_mute) else $error("mute pin ignored");
  property p_zero; 1'b1 |=> mute_pin_o == &$past(dac_zero_i) && mute_pin_oe_o == $past(mute_pin_floating_i);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_hw_tx; s_hw |=> primary_tx_o == {$past(serial_data_in_strap_i), 3'h2, 2'h0}; endproperty
  a_hw_tx: assert property (p_hw_tx) else $error("tx clocking wrong");
  property p_hw_pd; s_hw |=> powerdown_all_o == $past(global_powerdown_pin_i); endproperty
  a_hw_pd: assert property (p_hw_pd) else $error("powerdown pin ignored");
  property p_rst_pd; $rose(rst_n_i) |-> powerdown_all_o && dac_powerdown_o == '1; endproperty
  a_rst_pd: assert property (p_rst_pd) else $error("not down after reset");
  property p_mode; 1'b1 |=> mode_o == ctrl_mode_t'($past(hardware_mode_strap_i)); endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_sw_pin; s_sw_held |-> secondary_if_lr_clock_sel_o; endproperty
  a_sw_pin: assert property (p_sw_pin) else $error("pin function wrong");
endmodule
bind codec_control_regs_hw_mode codec_ctrl_asserts #(.DAC_COUNT(DAC_COUNT)) u_chk (.*);

/* File: verification/host_model.sv */
// Host controller model issuing register writes and reads
`timescale 1ns/10ps
module host_model import codec_ctrl_pkg::*; (
  input  wire logic      clk_sys_i,
  input  wire logic      rvalid_o,
  input  wire reg_word_t rdata_o,
  output reg_access_t    access_i
);
  initial access_i = '0;
  // callers pass words with unused bits zero
  task automatic wr(input logic [5:0] a, input reg_word_t d);
    @(negedge clk_sys_i);
    access_i <= {2'b10, a, d};
    @(negedge clk_sys_i);
    // Idle fields show the inverse so stale values cannot match
    access_i <= {2'b00, ~a, ~d};
  endtask
  task automatic rd(input logic [5:0] a, output reg_word_t d, output bit ok);
    @(negedge clk_sys_i);
    access_i <= {2'b01, a, 9'h000};
    @(negedge clk_sys_i);
    access_i <= {2'b00, ~a, 9'h1FF};
    ok = 0;
    for (int i = 0; i < 3 && !ok; i++) begin
      if (rvalid_o === 1'b1) begin
        ok = 1;
        d = rdata_o;
      end else begin
        @(negedge clk_sys_i);
      end
    end
  endtask
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the codec control bank
`timescale 1ns/10ps
module tb import codec_ctrl_pkg::*;;
  // Identity values are arbitrary
  localparam reg_word_t ID0 = 9'h0C1, ID1 = 9'h0C2, REV = 9'h003;
  logic clk_sys_i = 0, rst_n_i = 0, hardware_mode_strap_i = 0, mute_pin_i = 0, mute_pin_floating_i = 0;
  logic serial_data_in_strap_i = 0, global_powerdown_pin_i = 0, secondary_if_lr_clock_i = 0;
  logic rvalid_o, mute_pin_o, mute_pin_oe_o, secondary_if_lr_clock_sel_o, general_output_seven_o, powerdown_all_o;
  logic [3:0]   dac_zero_i = 4'h0, dac_soft_mute_o, dac_powerdown_o;
  reg_access_t  access_i;
  reg_word_t    rdata_o, pwr_main_o, pwr_aux_o;
  tx_clocking_t primary_tx_o;
  ctrl_mode_t   mode_o;
  int           err_total = 0, compares = 0;
  reg_word_t    dflt [36] = '{ID0, ID1, REV, 9'h014, 9'h121, 9'h17E, 9'h07D, 9'h194, 9'h010, 9'h002, 9'h002,
    9'h0C2, 9'h18A, 9'h08A, 9'h00A, 9'h0E4, 9'h009, 9'h000, 9'h0FF, 9'h000, 9'h0FF, 9'h0FF, 9'h0FF, 9'h0FF,
    9'h0FF, 9'h0FF, 9'h0FF, 9'h0FF, 9'h0FF, 9'h040, 9'h000, 9'h000, 9'h000, 9'h000, 9'h031, 9'h00B};
  always #25 clk_sys_i = ~clk_sys_i;
  codec_control_regs_hw_mode #(.ID_CODE_0(ID0), .ID_CODE_1(ID1), .REVISION(REV)) dut (.*);
  host_model host (.*);
  task automatic report_and_stop();
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk9(input reg_word_t got, input reg_word_t exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkp(input logic [5:0] got, input logic [5:0] exp);
    chk9({3'h0, got}, {3'h0, exp});
  endtask
  task automatic rd9(input logic [5:0] a, input reg_word_t exp);
    reg_word_t v;
    bit ok;
    host.rd(a, v, ok);
    if (ok) begin
      chk9(v, exp);
    end else begin
      err_total++;
      $display("mismatch %0t read not answered", $time);
      report_and_stop();
    end
  endtask
  task automatic settle();
    repeat (3) @(negedge clk_sys_i);
  endtask
  task automatic t_reset();
    @(negedge clk_sys_i);
    rst_n_i = 0;
    hardware_mode_strap_i = 0;
    repeat (20) @(negedge clk_sys_i);
    rst_n_i = 1;
  endtask
  task automatic t_defaults();
    for (int i = 0; i < 36; i++) begin
      rd9(i[5:0], dflt[i]);
    end
    rd9(6'h32, 9'h07E);
    rd9(6'h3F, 9'h000);
  endtask
  task automatic t_write_keep();
    host.wr(6'h11, 9'h015);
    rd9(6'h11, 9'h015);
    host.wr(6'h3F, 9'h1FF);
    host.wr(6'h23, 9'h0F3);
    rd9(6'h3F, 9'h000);
    rd9(6'h11, 9'h015);
    rd9(6'h23, 9'h0F3);
  endtask
  task automatic t_id_readback();
    host.wr(6'h00, 9'h0C3);
    rd9(6'h00, ID0);
    host.wr(6'h34, 9'h008);
    rd9(6'h00, 9'h0C3);
    host.wr(6'h34, 9'h000);
    rd9(6'h01, ID1);
  endtask
  task automatic t_sw_power();
    chkp(powerdown_all_o, 1);
    chk9(pwr_main_o, 9'h07E);
    chk9(pwr_aux_o, 9'h03E);
    host.wr(6'h32, 9'h000);
    secondary_if_lr_clock_i = 1;
    settle();
    chkp(powerdown_all_o, 0);
    chkp(dac_powerdown_o, 0);
    chk9(pwr_main_o, 9'h000);
    chkp(general_output_seven_o, 1);
  endtask
  task automatic t_sw_mute();
    host.wr(6'h10, 9'h029);
    mute_pin_i = 1;
    settle();
    chkp(dac_soft_mute_o, 4'b0100);
    host.wr(6'h13, 9'h080);
    settle();
    chkp(dac_soft_mute_o, 4'b0000);
  endtask
  task automatic t_hw_pins();
    hardware_mode_strap_i = 1;
    for (int i = 0; i < 8; i++) begin
      {mute_pin_i, serial_data_in_strap_i, global_powerdown_pin_i} = i[2:0];
      settle();
      chkp(mode_o, 1);
      chkp(dac_soft_mute_o, {4{i[2]}});
      chkp(primary_tx_o, {i[1], 3'h2, 2'h0});
      chkp(powerdown_all_o, i[0]);
    end
    mute_pin_floating_i = 1;
    for (int z = 0; z < 2; z++) begin
      dac_zero_i = {z[0], 3'h7};
      settle();
      chkp(mute_pin_oe_o, 1);
      chkp(dac_soft_mute_o, 0);
      chkp(mute_pin_o, z[0]);
    end
    mute_pin_floating_i = 0;
  endtask
  initial begin
    t_reset();
    t_defaults();
    t_write_keep();
    t_id_readback();
    t_sw_power();
    t_sw_mute();
    t_hw_pins();
    t_reset();
    rd9(6'h11, 9'h000);
    report_and_stop();
  end
endmodule
